// ==== pieb_pkg.sv ====
package pieb_pkg;
    localparam int unsigned ADDR_W = 12;
    // printed offsets are not multiples of four: kept as indices, byte address = 4 * index
    localparam logic [7:0] IDX_FLAGS_A   = 8'h0C;
    localparam logic [7:0] IDX_FLAGS_B   = 8'h0D;
    localparam logic [7:0] IDX_ENABLES_A = 8'h8C;
    localparam logic [7:0] IDX_ENABLES_B = 8'h8D;
    localparam logic [7:0] IDX_CONTROL   = 8'hC0;
    localparam logic [7:0] IDX_SOURCES   = 8'hC1;
    localparam int unsigned BIT_PARPORT  = 7;
    localparam int unsigned BIT_CONV     = 6;
    localparam int unsigned BIT_RX       = 5;
    localparam int unsigned BIT_TX       = 4;
    localparam int unsigned BIT_SYNC     = 3;
    localparam int unsigned BIT_CAPCMP1  = 2;
    localparam int unsigned BIT_TIMER_TWO_COUNT     = 1;
    localparam int unsigned BIT_TIMER_ONE_COUNT     = 0;
    localparam int unsigned BIT_CAPCMP2  = 0;
    localparam int unsigned BIT_PERIPH_EN = 0;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    // positions present in the reduced variant
    localparam logic [7:0] REDUCED_MASK  = 8'h4F;
    localparam logic [7:0] FULL_MASK     = 8'hFF;
    localparam logic [7:0] FLAG_B_MASK   = 8'h01;
    localparam logic [7:0] RO_FLAGS_A    = 8'h30;
    localparam logic [1:0] RESP_OKAY     = 2'b00;
    localparam logic [1:0] RESP_SLVERR   = 2'b10;
    typedef enum logic [1:0] {
        PIEB_CCP_CAPTURE = 2'b00,
        PIEB_CCP_COMPARE = 2'b01,
        PIEB_CCP_PWM     = 2'b10,
        PIEB_CCP_OFF     = 2'b11
    } pieb_ccp_mode_t;
endpackage : pieb_pkg

// ==== pieb_flag_if.sv ====
`timescale 1ns/1ps
interface pieb_flag_if;
    logic [7:0] flags_a;
    logic [7:0] flags_b;
    logic [7:0] enables_a;
    logic [7:0] enables_b;
    logic       periph_irq_en;
    logic       irq_req;
    modport bank (input flags_a, flags_b, enables_a, enables_b, periph_irq_en, output irq_req);
    modport top  (output flags_a, flags_b, enables_a, enables_b, periph_irq_en, input irq_req);
endinterface : pieb_flag_if

// ==== pieb_irq_gate.sv ====
`timescale 1ns/1ps
module pieb_irq_gate
    import pieb_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic aclk_en,
    pieb_flag_if.bank fi
);
    logic irq_q;
    logic irq_d;

    assign irq_d = fi.periph_irq_en &&
                   (|(fi.flags_a & fi.enables_a) || |(fi.flags_b & fi.enables_b));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else if (aclk_en) begin
            irq_q <= irq_d;
        end
    end
    assign fi.irq_req = irq_q;
endmodule : pieb_irq_gate

// ==== pieb_bank.sv ====
`timescale 1ns/1ps
module pieb_bank
    import pieb_pkg::*;
#(
    parameter bit REDUCED = 1'b0
)(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                aclk_en,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                parport_access,
    input  wire logic                conversion_done,
    input  wire logic                serial_rx_full,
    input  wire logic                serial_tx_empty,
    input  wire logic                sync_serial_done,
    input  wire logic [1:0]          capcmp_one_mode,
    input  wire logic                capcmp_one_capture,
    input  wire logic                capcmp_one_match,
    input  wire logic [1:0]          capcmp_two_mode,
    input  wire logic                capcmp_two_capture,
    input  wire logic                capcmp_two_match,
    input  wire logic                timer_two_match,
    input  wire logic                timer_one_ovf,
    output logic                     periph_irq_req
);
    // the decode reads address bits above the word index
    if (ADDR_W < 11) begin : g_addr_chk
        $error("address width too small for the register map");
    end

    localparam logic [7:0] IMPL_A = REDUCED ? REDUCED_MASK : FULL_MASK;

    function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
        word_idx = a[9:2];
    endfunction : word_idx

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = word_idx(a);
        addr_ok = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0) &&
                  (i == IDX_FLAGS_A || i == IDX_FLAGS_B || i == IDX_ENABLES_A ||
                   i == IDX_ENABLES_B || i == IDX_CONTROL || i == IDX_SOURCES);
    endfunction : addr_ok

    logic [7:0] flags_a_q;
    logic [7:0] flags_b_q;
    logic [7:0] enables_a_q;
    logic [7:0] enables_b_q;
    logic       periph_en_q;

    // write channel: capture address and data independently
    logic [ADDR_W-1:0] awaddr_q;
    logic              aw_have_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              w_have_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              wr_fire;
    logic [7:0]        wr_idx;
    logic              wr_lane0;
    logic [7:0]        wr_byte;

    // readies drop in reset and while frozen, so nothing is taken that is not stored
    assign s_axi_awready = aresetn && aclk_en && !aw_have_q && !bvalid_q;
    assign s_axi_wready  = aresetn && aclk_en && !w_have_q && !bvalid_q;
    assign wr_fire       = aclk_en && aw_have_q && w_have_q && !bvalid_q;
    assign wr_idx        = word_idx(awaddr_q);
    assign wr_lane0      = wstrb_q[0];
    assign wr_byte       = wdata_q[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (aclk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (aclk_en) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (aclk_en) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    // a frozen bank hides its answer so a master cannot take it twice
    assign s_axi_bvalid = bvalid_q && aclk_en;
    assign s_axi_bresp  = bresp_q;

    // write strobes per register, only low byte lane carries data
    logic we_flags_a;
    logic we_flags_b;
    logic we_en_a;
    logic we_en_b;
    logic we_ctrl;
    assign we_flags_a = wr_fire && wr_lane0 && addr_ok(awaddr_q) && wr_idx == IDX_FLAGS_A;
    assign we_flags_b = wr_fire && wr_lane0 && addr_ok(awaddr_q) && wr_idx == IDX_FLAGS_B;
    assign we_en_a    = wr_fire && wr_lane0 && addr_ok(awaddr_q) && wr_idx == IDX_ENABLES_A;
    assign we_en_b    = wr_fire && wr_lane0 && addr_ok(awaddr_q) && wr_idx == IDX_ENABLES_B;
    assign we_ctrl    = wr_fire && wr_lane0 && addr_ok(awaddr_q) && wr_idx == IDX_CONTROL;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enables_a_q <= RESET_BYTE;
            enables_b_q <= RESET_BYTE;
            periph_en_q <= 1'b0;
        end else if (aclk_en) begin
            if (we_en_a) begin
                enables_a_q <= wr_byte & IMPL_A;
            end
            if (we_en_b) begin
                enables_b_q <= wr_byte & FLAG_B_MASK;
            end
            if (we_ctrl) begin
                periph_en_q <= wr_byte[BIT_PERIPH_EN];
            end
        end
    end

    // pin inputs pass two flops before use
    localparam int unsigned NSRC = 13;
    logic [NSRC-1:0] src_raw;
    logic [NSRC-1:0] src_m_q;
    logic [NSRC-1:0] src_s_q;
    logic [NSRC-1:0] src_p_q;
    assign src_raw = {capcmp_two_mode, capcmp_one_mode, capcmp_two_capture, capcmp_two_match,
                      parport_access, conversion_done, sync_serial_done,
                      capcmp_one_capture, capcmp_one_match, timer_two_match, timer_one_ovf};
    logic [1:0] rxtx_m_q;
    logic [1:0] rxtx_s_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_m_q  <= '0;
            src_s_q  <= '0;
            src_p_q  <= '0;
            rxtx_m_q <= '0;
            rxtx_s_q <= '0;
        end else if (aclk_en) begin
            src_m_q  <= src_raw;
            src_s_q  <= src_m_q;
            src_p_q  <= src_s_q;
            rxtx_m_q <= {serial_rx_full, serial_tx_empty};
            rxtx_s_q <= rxtx_m_q;
        end
    end

    // events are rising edges of synchronised strobes, so a long strobe counts once
    logic [NSRC-1:0] rise;
    logic [1:0]      ccp1_mode;
    logic [1:0]      ccp2_mode;
    assign rise      = src_s_q & ~src_p_q;
    assign ccp2_mode = src_s_q[12:11];
    assign ccp1_mode = src_s_q[10:9];

    function automatic logic ccp_event(input logic [1:0] mode, input logic cap,
                                       input logic cmp);
        case (mode)
            PIEB_CCP_CAPTURE: ccp_event = cap;
            PIEB_CCP_COMPARE: ccp_event = cmp;
            default:          ccp_event = 1'b0;
        endcase
    endfunction : ccp_event

    logic [7:0] hw_set_a;
    logic [7:0] hw_set_b;
    always_comb begin
        hw_set_a = '0;
        hw_set_a[BIT_PARPORT] = rise[6];
        hw_set_a[BIT_CONV]    = rise[5];
        hw_set_a[BIT_SYNC]    = rise[4];
        hw_set_a[BIT_CAPCMP1] = ccp_event(ccp1_mode, rise[3], rise[2]);
        hw_set_a[BIT_TIMER_TWO_COUNT]    = rise[1];
        hw_set_a[BIT_TIMER_ONE_COUNT]    = rise[0];
        hw_set_a = hw_set_a & IMPL_A;
        hw_set_b = '0;
        hw_set_b[BIT_CAPCMP2] = ccp_event(ccp2_mode, rise[8], rise[7]);
    end

    // sticky flags: enables never gate the set; hardware set beats a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_a_q <= RESET_BYTE;
            flags_b_q <= RESET_BYTE;
        end else if (aclk_en) begin
            if (we_flags_a) begin
                flags_a_q <= ((wr_byte & ~RO_FLAGS_A & IMPL_A) | hw_set_a)
                             | (flags_a_q & RO_FLAGS_A);
            end else begin
                flags_a_q <= flags_a_q | hw_set_a;
            end
            if (we_flags_b) begin
                flags_b_q <= (wr_byte & FLAG_B_MASK) | hw_set_b;
            end else begin
                flags_b_q <= flags_b_q | hw_set_b;
            end
        end
    end

    // rx/tx positions are live buffer state, not stored
    logic [7:0] flags_a_view;
    always_comb begin
        flags_a_view = flags_a_q & ~RO_FLAGS_A;
        flags_a_view[BIT_RX] = rxtx_s_q[1];
        flags_a_view[BIT_TX] = rxtx_s_q[0];
        flags_a_view = flags_a_view & IMPL_A;
    end

    pieb_flag_if fi ();
    assign fi.flags_a       = flags_a_view;
    assign fi.flags_b       = flags_b_q;
    assign fi.enables_a     = enables_a_q;
    assign fi.enables_b     = enables_b_q;
    assign fi.periph_irq_en = periph_en_q;

    pieb_irq_gate u_gate (
        .aclk    (aclk),
        .aresetn (aresetn),
        .aclk_en (aclk_en),
        .fi      (fi)
    );
    assign periph_irq_req = fi.irq_req;

    // read channel: one cycle from address to data
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    assign s_axi_arready = aresetn && aclk_en && !rvalid_q;

    function automatic logic [7:0] read_mux(input logic [7:0] i);
        case (i)
            IDX_FLAGS_A:   read_mux = flags_a_view;
            IDX_FLAGS_B:   read_mux = flags_b_q;
            IDX_ENABLES_A: read_mux = enables_a_q;
            IDX_ENABLES_B: read_mux = enables_b_q;
            IDX_CONTROL:   read_mux = {7'h00, periph_en_q};
            IDX_SOURCES:   read_mux = {7'h00, periph_irq_req};
            default:       read_mux = 8'h00;
        endcase
    endfunction : read_mux

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (aclk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rdata_q  <= {24'h000000, read_mux(word_idx(s_axi_araddr))};
                rresp_q  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_rvalid = rvalid_q && aclk_en;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    sequence s_conv_pulse;
        aclk_en && rise[5] && !we_flags_a;
    endsequence

    a_flag_sticky_conv: assert property (@(posedge aclk) disable iff (!aresetn)
        s_conv_pulse |=> flags_a_q[BIT_CONV])
        else $error("conversion flag not set");
    a_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en && !we_flags_a && flags_a_q[BIT_TIMER_ONE_COUNT]) |=> flags_a_q[BIT_TIMER_ONE_COUNT])
        else $error("timer one flag lost without clear");
    a_set_wins_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (we_flags_a && rise[0]) |=> flags_a_q[BIT_TIMER_ONE_COUNT])
        else $error("hardware set lost to clear");
    a_pwm_no_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en && ccp1_mode == PIEB_CCP_PWM && !we_flags_a && !flags_a_q[BIT_CAPCMP1])
        |=> !flags_a_q[BIT_CAPCMP1])
        else $error("pwm mode drove capcmp flag");
    a_rx_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en ##1 aclk_en) |=>
        flags_a_view[BIT_RX] == ($past(serial_rx_full, 2) && IMPL_A[BIT_RX]))
        else $error("rx flag not mirroring buffer");
    a_reduced_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        ((flags_a_view | enables_a_q) & ~IMPL_A) == 8'h00)
        else $error("unimplemented bits nonzero");
    a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en && !periph_en_q) |=> !periph_irq_req)
        else $error("request without peripheral enable");
    a_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en && periph_en_q && |(flags_b_q & enables_b_q)) |=> periph_irq_req)
        else $error("request missing");
    a_timer2_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (aclk_en && rise[1]) |=> flags_a_q[BIT_TIMER_TWO_COUNT])
        else $error("timer two flag not set");
endmodule : pieb_bank

// ==== pieb_periph_model.sv ====
`timescale 1ns/1ps
module pieb_periph_model (
    input  wire logic       aclk,
    output logic [8:0]      ev,
    output logic            rx_full,
    output logic            tx_empty,
    output logic [1:0]      mode_one,
    output logic [1:0]      mode_two
);
    initial begin
        ev       = '0;
        rx_full  = 1'b0;
        tx_empty = 1'b0;
        mode_one = 2'b00;
        mode_two = 2'b00;
    end

    // mode settles through the bank's synchronisers before the event arrives
    task automatic fire(input int k, input logic [1:0] m);
        @(posedge aclk);
        mode_one <= m;
        mode_two <= m;
        repeat (3) @(posedge aclk);
        ev <= 9'(1 << k);
        @(posedge aclk);
        ev <= '0;
    endtask : fire

    // buffer levels are held, not pulsed, as real receive and transmit logic does
    task automatic set_bufs(input logic rx, input logic tx);
        @(posedge aclk);
        rx_full  <= rx;
        tx_empty <= tx;
    endtask : set_bufs
endmodule : pieb_periph_model

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    import pieb_pkg::*;
    logic              aclk, aresetn;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready, periph_irq_req;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp, mode_one, mode_two;
    logic [8:0]        ev;
    logic              rx_full, tx_empty;
    logic              aclk_en, jitter;
    logic [31:0]       red_rdata;
    logic [7:0]        rdq[$];
    logic [33:0]       rq[$];
    logic [1:0]        bq[$];
    int                fail_count, tests_run;

    pieb_periph_model i_per (.aclk(aclk), .ev(ev), .rx_full(rx_full), .tx_empty(tx_empty),
                             .mode_one(mode_one), .mode_two(mode_two));

    pieb_bank #(.REDUCED(1'b0)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .parport_access(ev[7]), .conversion_done(ev[6]), .serial_rx_full(rx_full),
        .serial_tx_empty(tx_empty), .sync_serial_done(ev[3]), .capcmp_one_mode(mode_one),
        .capcmp_one_capture(ev[2]), .capcmp_one_match(ev[4]), .capcmp_two_mode(mode_two),
        .capcmp_two_capture(ev[5]), .capcmp_two_match(ev[8]), .timer_two_match(ev[1]),
        .timer_one_ovf(ev[0]), .periph_irq_req(periph_irq_req));

    // reduced variant shadows the same bus; its handshakes track i_dut cycle for cycle
    pieb_bank #(.REDUCED(1'b1)) i_red (
        .aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
        .s_axi_rdata(red_rdata), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
        .parport_access(ev[7]), .conversion_done(ev[6]), .serial_rx_full(rx_full),
        .serial_tx_empty(tx_empty), .sync_serial_done(ev[3]), .capcmp_one_mode(mode_one),
        .capcmp_one_capture(ev[2]), .capcmp_one_match(ev[4]), .capcmp_two_mode(mode_two),
        .capcmp_two_capture(ev[5]), .capcmp_two_match(ev[8]), .timer_two_match(ev[1]),
        .timer_one_ovf(ev[0]), .periph_irq_req());

    // random stalls freeze both banks while transfers are in flight
    always @(posedge aclk) aclk_en <= !jitter || (($urandom & 1) != 0);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
        return ADDR_W'({idx, 2'b00});
    endfunction : ba

    task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // handshakes are judged mid-cycle, so the ready seen is the one the edge will sample
    always @(negedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            check("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
            check("read reduced", {26'h0, rdq.pop_front()}, {2'b00, red_rdata});
        end
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_hit, w_hit, aw_done, w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        bq.push_back(er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge aclk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit  = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (aw_hit) begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (w_hit) begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        do begin
            @(negedge aclk);
            aw_hit = s_axi_bvalid;
            @(posedge aclk);
        end while (!aw_hit);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [1:0] er);
        logic hit;
        rq.push_back({er, 24'h0, e});
        rdq.push_back((a == ba(IDX_FLAGS_A) || a == ba(IDX_ENABLES_A)) ? e & REDUCED_MASK : e);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(negedge aclk);
            hit = s_axi_arready;
            @(posedge aclk);
        end while (!hit);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            hit = s_axi_rvalid;
            @(posedge aclk);
        end while (!hit);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic irq_is(input logic e);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        check("irq", {33'h0, e}, {33'h0, periph_irq_req});
    endtask : irq_is

    initial begin
        #100us;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        logic [7:0]  regs[4];
        int          k;
        logic [31:0] r;
        regs = '{IDX_FLAGS_A, IDX_FLAGS_B, IDX_ENABLES_A, IDX_ENABLES_B};
        fail_count = 0;
        tests_run = 0;
        aresetn = 1'b0;
        jitter = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
        r = $urandom(58336);
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i]) rd(ba(regs[i]), 8'h00, RESP_OKAY);
        // every strobe source fires with all enables off
        for (int i = 0; i < 9; i++) begin
            i_per.fire(i, (i == 4 || i == 8) ? PIEB_CCP_COMPARE : PIEB_CCP_CAPTURE);
            repeat (4) @(posedge aclk);
            if (i == 5 || i == 8) begin
                rd(ba(IDX_FLAGS_B), 8'h01, RESP_OKAY);
                wr(ba(IDX_FLAGS_B), 32'h0, RESP_OKAY);
                rd(ba(IDX_FLAGS_B), 8'h00, RESP_OKAY);
            end else begin
                k = (i == 4) ? 2 : i;
                rd(ba(IDX_FLAGS_A), 8'(1 << k), RESP_OKAY);
                wr(ba(IDX_FLAGS_A), 32'h0, RESP_OKAY);
                rd(ba(IDX_FLAGS_A), 8'h00, RESP_OKAY);
            end
        end
        foreach (regs[i]) if (i < 2) i_per.fire(i == 0 ? 2 : 5, PIEB_CCP_PWM);
        i_per.fire(4, PIEB_CCP_PWM);
        i_per.fire(8, PIEB_CCP_PWM);
        i_per.fire(2, PIEB_CCP_OFF);
        i_per.fire(8, PIEB_CCP_OFF);
        repeat (4) @(posedge aclk);
        rd(ba(IDX_FLAGS_A), 8'h00, RESP_OKAY);
        rd(ba(IDX_FLAGS_B), 8'h00, RESP_OKAY);
        i_per.set_bufs(1'b1, 1'b0);
        repeat (4) @(posedge aclk);
        rd(ba(IDX_FLAGS_A), 8'h20, RESP_OKAY);
        wr(ba(IDX_FLAGS_A), 32'h0, RESP_OKAY);
        rd(ba(IDX_FLAGS_A), 8'h20, RESP_OKAY);
        i_per.set_bufs(1'b0, 1'b1);
        repeat (4) @(posedge aclk);
        rd(ba(IDX_FLAGS_A), 8'h10, RESP_OKAY);
        i_per.set_bufs(1'b0, 1'b0);
        repeat (4) @(posedge aclk);
        wr(ba(IDX_FLAGS_A), 32'hFF, RESP_OKAY);
        rd(ba(IDX_FLAGS_A), 8'hCF, RESP_OKAY);
        wr(ba(IDX_ENABLES_A), 32'hFF, RESP_OKAY);
        irq_is(1'b0);
        wr(ba(IDX_CONTROL), 32'h1, RESP_OKAY);
        irq_is(1'b1);
        rd(ba(IDX_SOURCES), 8'h01, RESP_OKAY);
        wr(ba(IDX_ENABLES_A), 32'h0, RESP_OKAY);
        irq_is(1'b0);
        wr(ba(IDX_FLAGS_A), 32'h0, RESP_OKAY);
        wr(ba(IDX_ENABLES_B), 32'hFF, RESP_OKAY);
        rd(ba(IDX_ENABLES_B), 8'h01, RESP_OKAY);
        irq_is(1'b0);
        i_per.fire(5, PIEB_CCP_CAPTURE);
        irq_is(1'b1);
        rd(ADDR_W'(12'h140), 8'h00, RESP_SLVERR);
        wr(ADDR_W'(12'h140), 32'hFF, RESP_SLVERR);
        wr(ba(IDX_ENABLES_A) + 1'b1, 32'hFF, RESP_SLVERR);
        rd(ba(IDX_ENABLES_A) + 1'b1, 8'h00, RESP_SLVERR);
        rd(ba(IDX_ENABLES_A), 8'h00, RESP_OKAY);
        jitter <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            wr(ba(IDX_ENABLES_A), r, RESP_OKAY);
            rd(ba(IDX_ENABLES_A), r[7:0], RESP_OKAY);
        end
        wr(ba(IDX_ENABLES_A), 32'h7F, RESP_OKAY);
        rd(ba(IDX_ENABLES_A), 8'h7F, RESP_OKAY);
        repeat (4) @(posedge aclk);
        tally_and_finish();
    end
endmodule : tb
